// ==== hw/eeprom_pkg.sv ====
// shared constants, opcodes and state encodings of the serial eeprom command port
// assumes one system clock at 125 MHz; all pins are asynchronous to it
// Behaviour
// - status pin low while programming, then high
// - status pin variant shows no polling on output
// - tolerate last address bit against dummy bit
// - ready shown until a start bit arrives
// - only rising shift clock edges act
// - polling needs no shift clock activity
// - after last address bit drive low dummy
// - dummy launched on edge sampling last address bit
// - sequential read continues at next address
// - sequential read wraps from top to zero
// - only first sequential word has dummy bit
// - erase sets contents to all ones
// - erase has no data field, data ones
// - all-ops use first two address bits
// - falling select starts the erase
// - programming finishes within 10 ms
// - write overwrites word; write-all fills memory
// - write carries full data; start variant dependent
// - leading zeros ignored; first one starts
// - width select high 16-bit, low 8-bit
// - polling output low busy, high ready

package eeprom_pkg;

	// ==========================================================
	// word and address geometry
	localparam int DATA_W   = 16;
	localparam int BYTE_W   = 8;
	localparam int ADDR_W16 = 6;
	localparam int OPC_W    = 2;
	localparam int CNT_W    = 5;

	// ==========================================================
	// instruction encodings
	localparam logic [1:0] OP_EXT    = 2'h0;
	localparam logic [1:0] OP_WRITE  = 2'h1;
	localparam logic [1:0] OP_READ   = 2'h2;
	localparam logic [1:0] OP_ERASE  = 2'h3;
	localparam logic [1:0] EXT_WRALL = 2'h1;
	localparam logic [1:0] EXT_ERALL = 2'h2;

	localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;
	localparam logic [1:0]        LANE_LO     = 2'h1;
	localparam logic [1:0]        LANE_HI     = 2'h2;
	localparam logic [1:0]        LANE_ALL    = 2'h3;
	localparam logic [1:0]        LOAD_START  = 2'h2;

	// ==========================================================
	// pin vector positions for the synchroniser
	localparam int PIN_CS  = 0;
	localparam int PIN_SK  = 1;
	localparam int PIN_DI  = 2;
	localparam int PIN_ORG = 3;
	localparam int PIN_N   = 4;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int NS_PER_MS     = 1000000;
	localparam int PROG_TIME_MS  = 10;
	// longest time, so the division rounds down
	localparam int PROG_CYCLES   = PROG_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;

	// ==========================================================
	// states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_OPC   = 3'h1,
		ST_ADDR  = 3'h3,
		ST_RDATA = 3'h2,
		ST_WDATA = 3'h6,
		ST_HOLD  = 3'h7
	} cmd_state_t;

	typedef enum logic [1:0] {
		PK_WRITE = 2'h0,
		PK_ERASE = 2'h1,
		PK_WRALL = 2'h2,
		PK_ERALL = 2'h3
	} prog_kind_t;

endpackage : eeprom_pkg

// ==== hw/pin_sync.sv ====
// two-stage synchroniser for a vector of asynchronous pins
// assumes each bit is an independent level; no bus coherence
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
	parameter int W = 4
) (
	input  wire logic         clk_sys_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] pins_i,
	output logic      [W-1:0] pins_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_t;

	sync_t r;
	sync_t n;

	always_comb begin
		n        = r;
		n.meta   = pins_i;
		n.stable = r.meta;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign pins_o = r.stable;

endmodule : pin_sync
`default_nettype wire

// ==== hw/eeprom_array.sv ====
// word-wide storage array with byte lane enables and registered read data
// assumes write and read addresses share one port; contents start undefined
`timescale 1ns/10ps
`default_nettype none

module eeprom_array #(
	parameter int DATA_W = 16,
	parameter int AW     = 6
) (
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	input  wire logic              we_i,
	input  wire logic [1:0]        lanes_i,
	input  wire logic [AW-1:0]     addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	output logic      [DATA_W-1:0] rdata_o
);
	localparam int HALF = DATA_W / 2;

	logic [DATA_W-1:0] mem [0:(1<<AW)-1];

	// storage is not reset: real cells keep their value over a reset
	always_ff @(posedge clk_sys_i) begin
		if (we_i && lanes_i[0]) begin
			mem[addr_i][HALF-1:0] <= wdata_i[HALF-1:0];
		end
		if (we_i && lanes_i[1]) begin
			mem[addr_i][DATA_W-1:HALF] <= wdata_i[DATA_W-1:HALF];
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= mem[addr_i];
		end
	end

endmodule : eeprom_array
`default_nettype wire

// ==== hw/eeprom_cmd_port.sv ====
// serial command port of a small eeprom: instruction decode, read-out,
// self-timed erase and write cycles, ready/busy on output or status pin
// assumes all pins asynchronous to clk_sys_i; host keeps its own rules
`timescale 1ns/10ps
`default_nettype none

module eeprom_cmd_port
	import eeprom_pkg::*;
#(
	parameter bit HAS_STATUS_PIN  = 1'b0,
	parameter bit SEQ_READ        = 1'b1,
	parameter bit PROG_ON_CS_FALL = 1'b1,
	parameter int AW              = eeprom_pkg::ADDR_W16,
	parameter int PROG_CYCLES     = eeprom_pkg::PROG_CYCLES
) (
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	input  wire logic cs_i,
	input  wire logic shift_clock_in_i,
	input  wire logic serial_in_i,
	input  wire logic word_width_select_i,
	output logic      data_out_o,
	output logic      data_out_oe_n_o,
	output logic      status_o
);
	import eeprom_pkg::*;

	// ==========================================================
	// derived sizes
	localparam int BAW   = AW + 1;
	localparam int WORDS = 1 << AW;
	localparam int PCW   = $clog2(PROG_CYCLES + 1);

	localparam logic [CNT_W-1:0] ALAST16 = CNT_W'(AW - 1);
	localparam logic [CNT_W-1:0] ALAST8  = CNT_W'(AW);
	localparam logic [CNT_W-1:0] WLAST16 = CNT_W'(DATA_W - 1);
	localparam logic [CNT_W-1:0] WLAST8  = CNT_W'(BYTE_W - 1);
	localparam logic [CNT_W-1:0] OPLAST  = CNT_W'(OPC_W - 1);
	localparam logic [PCW-1:0]   PLAST   = PCW'(PROG_CYCLES - 1);
	localparam logic [PCW-1:0]   PWORDS  = PCW'(WORDS);

	typedef struct packed {
		cmd_state_t        st;
		logic              cs_q;
		logic              sk_q;
		logic              org16;
		logic [OPC_W-1:0]  opc;
		logic [CNT_W-1:0]  cnt;
		logic [BAW-1:0]    addr;
		logic [DATA_W-1:0] sh;
		logic [1:0]        load;
		logic              armed;
		prog_kind_t        kind;
		logic              busy;
		logic              poll;
		logic [PCW-1:0]    pcnt;
		prog_kind_t        pkind;
		logic [BAW-1:0]    paddr;
		logic [DATA_W-1:0] pdata;
		logic              porg16;
		logic              dout;
		logic              doe_n;
		logic              status;
	} state_t;

	localparam state_t RST_VAL = '{
		st:      ST_IDLE,
		kind:    PK_WRITE,
		pkind:   PK_WRITE,
		doe_n:   1'b1,
		status:  1'b1,
		default: '0
	};

	// ==========================================================
	// address helpers; 8-bit mode keeps the byte select in bit 0
	function automatic logic [AW-1:0] word_of(input logic [BAW-1:0] a, input logic org16);
		word_of = org16 ? a[AW-1:0] : a[AW:1];
	endfunction : word_of

	function automatic logic [1:0] lanes_of(input logic [BAW-1:0] a, input logic org16);
		lanes_of = org16 ? LANE_ALL : (a[0] ? LANE_HI : LANE_LO);
	endfunction : lanes_of

	function automatic logic [BAW-1:0] next_addr(input logic [BAW-1:0] a, input logic org16);
		logic [AW-1:0] lo;
		lo = a[AW-1:0] + 1'b1;
		next_addr = org16 ? {1'b0, lo} : a + 1'b1;
	endfunction : next_addr

	function automatic logic [1:0] ext_of(input logic [BAW-1:0] a, input logic org16);
		ext_of = org16 ? a[AW-1 -: 2] : a[AW -: 2];
	endfunction : ext_of

	// ==========================================================
	// pin synchronisers
	logic [PIN_N-1:0] pins_s;

	pin_sync #(
		.W (PIN_N)
	) u_sync (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.pins_i    ({word_width_select_i, serial_in_i, shift_clock_in_i, cs_i}),
		.pins_o    (pins_s)
	);

	logic cs_s;
	logic sk_s;
	logic di_s;
	logic org_s;

	assign cs_s  = pins_s[PIN_CS];
	assign sk_s  = pins_s[PIN_SK];
	assign di_s  = pins_s[PIN_DI];
	assign org_s = pins_s[PIN_ORG];

	// ==========================================================
	// storage
	logic              mem_we;
	logic [1:0]        mem_lanes;
	logic [AW-1:0]     mem_addr;
	logic [DATA_W-1:0] mem_wdata;
	logic [DATA_W-1:0] mem_rdata;

	eeprom_array #(
		.DATA_W (DATA_W),
		.AW     (AW)
	) u_array (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.we_i      (mem_we),
		.lanes_i   (mem_lanes),
		.addr_i    (mem_addr),
		.wdata_i   (mem_wdata),
		.rdata_o   (mem_rdata)
	);

	// ==========================================================
	// next state
	state_t r;
	state_t n;

	logic             rise;
	logic             cs_fall;
	logic             start;
	logic [BAW-1:0]   na;
	logic [CNT_W-1:0] alast;
	logic [CNT_W-1:0] wlast;

	always_comb begin
		n         = r;
		start     = 1'b0;
		na        = {r.addr[BAW-2:0], di_s};
		alast     = r.org16 ? ALAST16 : ALAST8;
		wlast     = r.org16 ? WLAST16 : WLAST8;
		rise      = sk_s && !r.sk_q && cs_s;
		cs_fall   = r.cs_q && !cs_s;
		n.cs_q    = cs_s;
		n.sk_q    = sk_s;
		mem_we    = 1'b0;
		mem_lanes = LANE_ALL;
		mem_addr  = word_of(r.addr, r.org16);
		mem_wdata = ERASED_WORD;

		// read word arrives two cycles after the address settles
		if (r.load != 2'h0) begin
			n.load = r.load - 2'h1;
			if (r.load == 2'h1) begin
				n.sh = r.org16 ? mem_rdata
					: {(r.addr[0] ? mem_rdata[DATA_W-1:BYTE_W]
						: mem_rdata[BYTE_W-1:0]), {BYTE_W{1'b0}}};
			end
		end

		if (!cs_s) begin
			n.st    = ST_IDLE;
			n.armed = 1'b0;
			n.load  = 2'h0;
			if (cs_fall && !r.busy) begin
				if (r.st == ST_HOLD && r.armed) begin
					start = 1'b1;
				end else if (r.st == ST_WDATA && PROG_ON_CS_FALL) begin
					start = 1'b1;
				end
			end
		end else if (rise) begin
			unique case (r.st)
				ST_IDLE: begin
					// a busy array accepts nothing
					if (di_s && !r.busy) begin
						n.st    = ST_OPC;
						n.cnt   = '0;
						n.addr  = '0;
						n.poll  = 1'b0;
						n.org16 = org_s;
					end
				end
				ST_OPC: begin
					n.opc = {r.opc[0], di_s};
					n.cnt = r.cnt + 1'b1;
					if (r.cnt == OPLAST) begin
						n.st  = ST_ADDR;
						n.cnt = '0;
					end
				end
				ST_ADDR: begin
					n.addr = na;
					n.cnt  = r.cnt + 1'b1;
					if (r.cnt == alast) begin
						n.cnt = '0;
						unique case (r.opc)
							OP_READ: begin
								n.st   = ST_RDATA;
								n.dout = 1'b0;
								n.load = LOAD_START;
							end
							OP_WRITE: begin
								n.st   = ST_WDATA;
								n.kind = PK_WRITE;
							end
							OP_ERASE: begin
								n.st    = ST_HOLD;
								n.armed = 1'b1;
								n.kind  = PK_ERASE;
							end
							OP_EXT: begin
								n.st = ST_HOLD;
								// remaining address bits are don't care
								if (ext_of(na, r.org16) == EXT_WRALL) begin
									n.st   = ST_WDATA;
									n.kind = PK_WRALL;
								end else if (ext_of(na, r.org16) == EXT_ERALL) begin
									n.armed = 1'b1;
									n.kind  = PK_ERALL;
								end
							end
						endcase
					end
				end
				ST_RDATA: begin
					if (r.cnt <= wlast) begin
						n.dout = r.sh[DATA_W-1];
						n.sh   = {r.sh[DATA_W-2:0], 1'b0};
						n.cnt  = r.cnt + 1'b1;
						if (r.cnt == wlast && SEQ_READ) begin
							// next word follows with no dummy bit
							n.addr = next_addr(r.addr, r.org16);
							n.load = LOAD_START;
							n.cnt  = '0;
						end
					end else begin
						// without sequential read the input falls through
						n.dout = di_s;
					end
				end
				ST_WDATA: begin
					// keeps the most recent bits when extra clocks are allowed
					n.sh = {r.sh[DATA_W-2:0], di_s};
					if (r.cnt != wlast) begin
						n.cnt = r.cnt + 1'b1;
					end else if (!PROG_ON_CS_FALL) begin
						n.st  = ST_HOLD;
						start = 1'b1;
					end
				end
				ST_HOLD: begin
				end
				default: begin
					n.st = ST_IDLE;
				end
			endcase
		end

		if (start) begin
			n.busy   = 1'b1;
			n.poll   = 1'b1;
			n.pcnt   = '0;
			n.pkind  = r.kind;
			n.paddr  = r.addr;
			n.porg16 = r.org16;
			n.pdata  = (r.kind == PK_ERASE || r.kind == PK_ERALL) ? ERASED_WORD : n.sh;
		end

		// self-timed cycle: stores first, then waits out the full time
		if (r.busy) begin
			n.pcnt = r.pcnt + 1'b1;
			if (r.pkind == PK_WRALL || r.pkind == PK_ERALL) begin
				mem_we   = (r.pcnt < PWORDS);
				mem_addr = r.pcnt[AW-1:0];
			end else begin
				mem_we    = (r.pcnt == '0);
				mem_addr  = word_of(r.paddr, r.porg16);
				mem_lanes = lanes_of(r.paddr, r.porg16);
			end
			mem_wdata = r.porg16 ? r.pdata : {2{r.pdata[BYTE_W-1:0]}};
			if (r.pcnt == PLAST) begin
				n.busy = 1'b0;
			end
		end

		// polling works from select alone, no clock needed
		if (n.poll && !HAS_STATUS_PIN && cs_s) begin
			n.dout = !n.busy;
		end
		n.doe_n  = !(cs_s && ((n.poll && !HAS_STATUS_PIN) || n.st == ST_RDATA));
		n.status = HAS_STATUS_PIN ? !n.busy : 1'b1;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			r <= RST_VAL;
		end else begin
			r <= n;
		end
	end

	// ==========================================================
	// outputs
	assign data_out_o      = r.dout;
	assign data_out_oe_n_o = r.doe_n;
	assign status_o        = r.status;

endmodule : eeprom_cmd_port
`default_nettype wire

// ==== dv/eeprom_host_model.sv ====
// host side of the serial link: select, shift clock and serial data in
// assumes a four-wire hookup; data out is sampled late in the high phase of checked bits
`timescale 1ns/10ps
`default_nettype none

module eeprom_host_model #(
	parameter int PROG_NS = 1800
) (
	output var logic       cs_o,
	output var logic       sk_o,
	output var logic       di_o,
	input  wire logic      do_i,
	input  wire logic      oe_n_i,
	output var logic       smp_o,
	output var logic [1:0] seen_o
);
	logic last;
	// released line shows the inverse of its last level, not a kind value
	wire  do_w = oe_n_i ? ~last : do_i;

	initial begin
		cs_o = 1'b0;
		sk_o = 1'b0;
		di_o = 1'b0;
		smp_o = 1'b0;
		seen_o = 2'b00;
		last = 1'b0;
	end

	always @(do_i or oe_n_i) begin
		if (!oe_n_i)
			last = do_i;
	end

	// ==========================================================
	// bit level
	// takes no time, so every pin change stays on a falling system clock edge
	task automatic look();
		seen_o = {oe_n_i, oe_n_i ? 1'b0 : do_w};
		smp_o = 1'b1;
		smp_o <= #1 1'b0;
	endtask : look

	// clock parked low, one clean pulse per bit, never a stray one
	task automatic bitx(input logic b, input logic chk);
		di_o = b;
		#24 sk_o = 1'b1;
		#38;
		if (chk)
			look();
		#2 sk_o = 1'b0;
	endtask : bitx

	task automatic sel(input logic b);
		cs_o = b;
		di_o = 1'b0;
		#40;
	endtask : sel

	task automatic shift(input logic [31:0] v, input int n, input logic chk);
		for (int i = n - 1; i >= 0; i--)
			bitx(v[i], chk);
	endtask : shift

	// ==========================================================
	// frames
	task automatic rd(input logic [31:0] v, input int n, input int nout);
		sel(1'b1);
		shift(v >> 1, n - 1, 1'b0);
		bitx(v[0], 1'b1);
		repeat (nout) bitx(1'b0, 1'b1);
		sel(1'b0);
	endtask : rd

	task automatic prog(input logic [31:0] v, input int n);
		sel(1'b1);
		shift(v, n, 1'b0);
		sel(1'b0);
		sel(1'b1);
		look();
		#(PROG_NS) look();
		sel(1'b0);
		sel(1'b1);
		look();
		bitx(1'b1, 1'b0);
		#8 look();
		sel(1'b0);
	endtask : prog
endmodule : eeprom_host_model
`default_nettype wire

// ==== dv/eeprom_cmd_port_checker.sv ====
// assertions on the pins of the eeprom command port
// assumes it is bound to eeprom_cmd_port and sees only its ports
`timescale 1ns/10ps
`default_nettype none

module eeprom_cmd_port_checker #(
	parameter bit HAS_STATUS_PIN = 1'b0,
	parameter int PROG_CYCLES    = 200
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic cs_i,
	input wire logic shift_clock_in_i,
	input wire logic serial_in_i,
	input wire logic word_width_select_i,
	input wire logic data_out_o,
	input wire logic data_out_oe_n_o,
	input wire logic status_o
);
	int busy_cnt;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	// busy shown with no clock activity; read zeros never last this long
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			busy_cnt <= 0;
		else if (!data_out_oe_n_o && !data_out_o && !shift_clock_in_i)
			busy_cnt <= busy_cnt + 1;
		else
			busy_cnt <= 0;
	end

	// ==========================================================
	// assertions
	AST_STATUS_READY: assert property (!HAS_STATUS_PIN |-> status_o)
		else $error("status pin left its ready level");
	AST_CS_LOW_RELEASE: assert property (!cs_i [*5] |-> data_out_oe_n_o)
		else $error("data out driven while unselected");
	AST_DRIVE_NEEDS_CS: assert property (!data_out_oe_n_o |-> $past(cs_i, 3) || $past(cs_i, 4))
		else $error("data out driven without recent select");
	AST_DUMMY_LOW: assert property ($fell(data_out_oe_n_o) && shift_clock_in_i |-> !data_out_o)
		else $error("read output not started with a low dummy");
	AST_FALL_NO_EFFECT: assert property ($fell(shift_clock_in_i) && cs_i |=> ($stable(data_out_o) || data_out_oe_n_o) [*3])
		else $error("falling shift clock moved data out");
	AST_RELEASE_CAUSE: assert property ($rose(data_out_oe_n_o) |-> !$past(cs_i, 3) || $past(shift_clock_in_i, 3))
		else $error("data out released without cause");
	AST_READY_STANDS: assert property (cs_i && !shift_clock_in_i && !data_out_oe_n_o && data_out_o |=> data_out_o || data_out_oe_n_o)
		else $error("ready level dropped without a start bit");
	AST_BUSY_BOUNDED: assert property (busy_cnt <= PROG_CYCLES)
		else $error("busy shown longer than a programming cycle");
endmodule : eeprom_cmd_port_checker
`default_nettype wire

// ==== dv/serial_eeprom_command_port_test.sv ====
// self-checking bench: host model sends frames, expected bits are queued
// assumes a 125 MHz system clock and a 64 ns shift clock from the host
`timescale 1ns/10ps
`default_nettype none

module serial_eeprom_command_port_test;
	import eeprom_pkg::*;
	localparam int PROG = 200;

	logic        clk_sys_i;
	logic        rst_i;
	logic        wws;
	wire         cs;
	wire         sk;
	wire         di;
	wire         dout;
	wire         oe_n;
	wire         status;
	wire         smp;
	wire  [1:0]  seen;
	wire         dout2;
	wire         oe2_n;
	wire         status2;
	wire  [1:0]  seen2;
	logic [1:0]  q[$];
	logic [2:0]  q2[$];
	int          err_total;
	int          n_tests;
	int          seed;
	logic [15:0] pat;
	logic [15:0] wv;
	logic [7:0]  bv;

	eeprom_cmd_port #(.PROG_CYCLES(PROG)) dut_u (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_i(cs), .shift_clock_in_i(sk),
		.serial_in_i(di), .word_width_select_i(wws), .data_out_o(dout),
		.data_out_oe_n_o(oe_n), .status_o(status));

	// status pin variant on the same host lines; its data out never shows polling
	eeprom_cmd_port #(.HAS_STATUS_PIN(1'b1), .PROG_CYCLES(PROG)) dut_stat_u (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_i(cs), .shift_clock_in_i(sk),
		.serial_in_i(di), .word_width_select_i(wws), .data_out_o(dout2),
		.data_out_oe_n_o(oe2_n), .status_o(status2));

	assign seen2 = {oe2_n, oe2_n ? 1'b0 : dout2};

	// host default wait covers PROG cycles plus margin
	eeprom_host_model host_u (
		.cs_o(cs), .sk_o(sk), .di_o(di), .do_i(dout), .oe_n_i(oe_n),
		.smp_o(smp), .seen_o(seen));

	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	// ==========================================================
	// expectations and checking
	task automatic expect_bits(input logic [15:0] v, input int n, input logic dummy);
		if (dummy) begin
			q.push_back(2'b00);
			q2.push_back(3'b100);
		end
		for (int i = n - 1; i >= 0; i--) begin
			q.push_back({1'b0, v[i]});
			q2.push_back({2'b10, v[i]});
		end
	endtask : expect_bits

	// busy, ready, ready again, released after the clearing start bit
	task automatic prog(input logic [31:0] v, input int n);
		q.push_back(2'b00);
		q.push_back(2'b01);
		q.push_back(2'b01);
		q.push_back(2'b10);
		// status variant: pin low while busy, then high; data out stays released
		q2.push_back(3'b010);
		q2.push_back(3'b110);
		q2.push_back(3'b110);
		q2.push_back(3'b110);
		host_u.prog(v, n);
	endtask : prog

	always @(posedge smp) begin
		n_tests++;
		if (q.size() == 0 || seen !== q[0]) begin
			err_total++;
			$display("Error dout expected %b seen %b", q.size() ? q[0] : 2'bxx, seen);
		end
		if (q.size() != 0)
			void'(q.pop_front());
		if (q2.size() == 0 || {status2, seen2} !== q2[0]) begin
			err_total++;
			$display("Error status2 expected %b seen %b", q2.size() ? q2[0] : 3'bxxx,
				{status2, seen2});
		end
		if (q2.size() != 0)
			void'(q2.pop_front());
		if (status !== 1'b1) begin
			err_total++;
			$display("Error status expected 1 seen %b", status);
		end
	end

	task automatic conclude();
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	initial begin
		#300000;
		err_total++;
		conclude();
	end

	// ==========================================================
	// scenarios
	initial begin
		rst_i = 1'b1;
		wws = 1'b1;
		err_total = 0;
		n_tests = 0;
		seed = $urandom(32'hd52b7bdd);
		pat = 16'($urandom());
		wv = 16'($urandom());
		bv = 8'($urandom());
		repeat (2) @(posedge clk_sys_i);
		@(negedge clk_sys_i) rst_i = 1'b0;
		repeat (4) @(negedge clk_sys_i);
		prog({1'b1, OP_EXT, EXT_WRALL, 4'($urandom()), pat}, 25);
		prog({1'b1, OP_WRITE, 6'h3f, wv}, 25);
		prog({1'b1, OP_ERASE, 6'h00}, 9);
		expect_bits(pat, 16, 1'b1);
		expect_bits(wv, 16, 1'b0);
		expect_bits(ERASED_WORD, 16, 1'b0);
		host_u.rd({3'h0, 1'b1, OP_READ, 6'h3e}, 12, 48);
		@(negedge clk_sys_i) wws = 1'b0;
		prog({1'b1, OP_WRITE, 7'h01, bv}, 18);
		expect_bits({8'hff, bv}, 16, 1'b1);
		host_u.rd({1'b1, OP_READ, 7'h00}, 10, 16);
		@(negedge clk_sys_i) wws = 1'b1;
		expect_bits({bv, 8'hff}, 16, 1'b1);
		host_u.rd({1'b1, OP_READ, 6'h00}, 9, 16);
		prog({1'b1, OP_EXT, EXT_ERALL, 4'($urandom())}, 9);
		expect_bits(ERASED_WORD, 16, 1'b1);
		host_u.rd({1'b1, OP_READ, 6'h3f}, 9, 16);
		if (q.size() != 0 || q2.size() != 0)
			err_total++;
		conclude();
	end
endmodule : serial_eeprom_command_port_test

bind eeprom_cmd_port eeprom_cmd_port_checker #(
	.HAS_STATUS_PIN(HAS_STATUS_PIN), .PROG_CYCLES(PROG_CYCLES)) chk_u (
	.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_i(cs_i), .shift_clock_in_i(shift_clock_in_i),
	.serial_in_i(serial_in_i), .word_width_select_i(word_width_select_i),
	.data_out_o(data_out_o), .data_out_oe_n_o(data_out_oe_n_o), .status_o(status_o));
`default_nettype wire
